// file: inc/afilt_defines.vh
// Constants of the shared identifier acceptance filter.
// Assumes 32-bit word accesses on a byte-addressed register port.
`ifndef AFILT_DEFINES_VH
`define AFILT_DEFINES_VH

// ----------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------
`define A_CTRL       12'h800
`define A_STD_EXP    12'h804
`define A_STD_GRP    12'h808
`define A_EXT_EXP    12'h80c
`define A_EXT_GRP    12'h810
`define A_EOT        12'h814
`define A_STATUS     12'h818
`define TAB_SEL_BIT  11

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define CTRL_DS_EN   0
`define ST_BUSY      0
`define ST_ACCEPT    1
`define ST_DIRECT    2
`define ST_IDX_LSB   16
`define OFS_MASK     12'hffc

// ----------------------------------------------------------
// Entry layout inside one halfword or one word
// ----------------------------------------------------------
`define H_CTRL_HI    15
`define H_CTRL_LO    13
`define H_DIS        12
`define H_ID_HI      10
`define H_ID_LO      0
`define W_CTRL_HI    31
`define W_CTRL_LO    29
`define W_ID_HI      28

// ----------------------------------------------------------
// Table geometry and object size
// ----------------------------------------------------------
`define TAB_WORDS    512
`define OBJ_WORDS    3
`define RST_OFS      12'h000

`endif

// file: rtl/can_id_acceptance_lookup.v
// Shared acceptance filter for received CAN identifiers.
// Assumes receive paths present one request at a time and software uses
// whole 32-bit words on the register port.
//
// Overview of operation
// RQ1: One shared table filters all controllers
// RQ2: Table is 512 words of 32 bits
// RQ3: Holds 1024 standard, 512 extended, or mixed
// RQ4: Software uses full 32-bit words only
// RQ5: Five ordered sections, direct-store first
// RQ6: Direct-store hits go into table memory
// RQ7: Five start-offset registers mark section boundaries
// RQ8: Direct-store at zero, others at registers
// RQ9: Message object area starts at end offset
// RQ10: Equal consecutive offsets mean empty section
// RQ11: Direct-store searched only when enabled
// RQ12: Software keeps direct-store entries ascending, paired
// RQ13: Match needs identifier and controller agreement
// RQ14: Direct-store indices run from zero upward
// RQ15: Even entry upper halfword, odd lower
// RQ16: Search direct-store first, then later sections
// RQ17: Object at end offset plus twelve times index
// RQ18: Software wins port; searches run whole
// RQ19: Disabled entries never match
//
// The strobed register port and the register addresses were left to the implementer.
`include "afilt_defines.vh"
module can_id_acceptance_lookup #(
   parameter DEPTH = `TAB_WORDS,
   parameter AW    = 9
) (
   // Clock and reset
   input  wire        mclk_i,
   input  wire        rstn_i,
   // Register port
   input  wire [11:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   // Search request from receive paths
   input  wire        req_i,
   input  wire [2:0]  req_ctrl_i,
   input  wire        req_ext_i,
   input  wire        req_rtr_i,
   input  wire [3:0]  req_dlc_i,
   input  wire [28:0] req_id_i,
   input  wire [31:0] req_data_a_i,
   input  wire [31:0] req_data_b_i,
   // Search result
   output reg         busy_o,
   output reg         done_o,
   output reg         accept_o,
   output reg         direct_o,
   output reg  [9:0]  index_o
);

   localparam S_IDLE  = 2'b00;
   localparam S_SCAN  = 2'b01;
   localparam S_STORE = 2'b10;

   localparam SEC_DS  = 3'd0;
   localparam SEC_SE  = 3'd1;
   localparam SEC_SG  = 3'd2;
   localparam SEC_EE  = 3'd3;
   localparam SEC_EG  = 3'd4;

   // ----------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------
   reg        ds_en;
   reg [11:0] std_exp_ofs;
   reg [11:0] std_grp_ofs;
   reg [11:0] ext_exp_ofs;
   reg [11:0] ext_grp_ofs;
   reg [11:0] eot_ofs;

   // ----------------------------------------------------------
   // Search state
   // ----------------------------------------------------------
   reg [1:0]  state;
   reg [2:0]  sec;
   reg [9:0]  ptr;
   reg        phase;
   reg [31:0] low_word;
   reg [2:0]  ctrl;
   reg        ext;
   reg        rtr;
   reg [3:0]  dlc;
   reg [28:0] id;
   reg [31:0] data_a;
   reg [31:0] data_b;
   reg [9:0]  hit_idx;
   reg [1:0]  cnt;
   reg        st_accept;
   reg        st_direct;
   reg [9:0]  st_idx;

   wire       tab_sel = !addr_i[`TAB_SEL_BIT];
   // RQ18 software owns port this cycle
   wire       sw_acc  = (wr_i || rd_i) && tab_sel;

   function [9:0] word_of;
      input [11:0] ofs;
      begin
         word_of = ofs[11:2];
      end
   endfunction

   // RQ17 object at end plus 3 words per index
   function [11:0] obj_word;
      input [11:0] eot;
      input [9:0]  idx;
      input [1:0]  k;
      begin
         obj_word = {2'b00, word_of(eot)} + ({2'b00, idx} * 12'h003) + {10'h000, k};
      end
   endfunction

   // ----------------------------------------------------------
   // Section bounds
   // ----------------------------------------------------------
   reg [9:0] hi;
   always @* begin
      // RQ8 RQ9 bounds from registers
      case (sec)
         SEC_DS:  hi = word_of(std_exp_ofs);
         SEC_SE:  hi = word_of(std_grp_ofs);
         SEC_SG:  hi = word_of(ext_exp_ofs);
         SEC_EE:  hi = word_of(ext_grp_ofs);
         default: hi = word_of(eot_ofs);
      endcase
   end

   // ----------------------------------------------------------
   // Shared memory port
   // ----------------------------------------------------------
   wire [11:0] store_w = obj_word(eot_ofs, hit_idx, cnt);
   reg  [31:0] store_data;
   always @* begin
      case (cnt)
         2'd0:    store_data = {1'b0, rtr, 10'h000, dlc, 5'h00, id[10:0]};
         2'd1:    store_data = data_a;
         default: store_data = data_b;
      endcase
   end

   wire          do_store = (state == S_STORE) && !sw_acc;
   wire [AW-1:0] mem_addr = sw_acc ? addr_i[AW+1:2] :
                            ((state == S_STORE) ? store_w[AW-1:0] : ptr[AW-1:0]);
   // RQ4 whole-word writes only
   wire          mem_we   = (wr_i && tab_sel) || do_store;
   wire [31:0]   mem_wd   = sw_acc ? wdata_i : store_data;
   wire [31:0]   mem_q;

   // RQ2 512 by 32 table
   id_table_ram #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_ram (
      .mclk_i  (mclk_i),
      .addr_i  (mem_addr),
      .we_i    (mem_we),
      .wdata_i (mem_wd),
      .rdata_o (mem_q)
   );

   wire hit_hi;
   wire hit_lo;
   wire hit_sr;
   wire hit_ex;
   wire hit_er;

   entry_match u_match (
      .word_i          (mem_q),
      .low_word_i      (low_word),
      .ctrl_i          (ctrl),
      .id_i            (id),
      .hit_hi_o        (hit_hi),
      .hit_lo_o        (hit_lo),
      .hit_std_range_o (hit_sr),
      .hit_ext_o       (hit_ex),
      .hit_ext_range_o (hit_er)
   );

   // ----------------------------------------------------------
   // Register writes and reads
   // ----------------------------------------------------------
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ds_en       <= 1'b0;
         std_exp_ofs <= `RST_OFS;
         std_grp_ofs <= `RST_OFS;
         ext_exp_ofs <= `RST_OFS;
         ext_grp_ofs <= `RST_OFS;
         eot_ofs     <= `RST_OFS;
         rdata_o     <= 32'h0000_0000;
      end else begin
         if (wr_i) begin
            // RQ7 five start-offset registers
            if (addr_i == `A_CTRL) begin
               ds_en <= wdata_i[`CTRL_DS_EN];
            end else if (addr_i == `A_STD_EXP) begin
               std_exp_ofs <= wdata_i[11:0] & `OFS_MASK;
            end else if (addr_i == `A_STD_GRP) begin
               std_grp_ofs <= wdata_i[11:0] & `OFS_MASK;
            end else if (addr_i == `A_EXT_EXP) begin
               ext_exp_ofs <= wdata_i[11:0] & `OFS_MASK;
            end else if (addr_i == `A_EXT_GRP) begin
               ext_grp_ofs <= wdata_i[11:0] & `OFS_MASK;
            end else if (addr_i == `A_EOT) begin
               eot_ofs <= wdata_i[11:0] & `OFS_MASK;
            end
         end
         if (!rd_i) begin
            rdata_o <= 32'h0000_0000;
         end else if (tab_sel) begin
            rdata_o <= mem_q;
         end else if (addr_i == `A_CTRL) begin
            rdata_o <= {31'h0000_0000, ds_en};
         end else if (addr_i == `A_STD_EXP) begin
            rdata_o <= {20'h00000, std_exp_ofs};
         end else if (addr_i == `A_STD_GRP) begin
            rdata_o <= {20'h00000, std_grp_ofs};
         end else if (addr_i == `A_EXT_EXP) begin
            rdata_o <= {20'h00000, ext_exp_ofs};
         end else if (addr_i == `A_EXT_GRP) begin
            rdata_o <= {20'h00000, ext_grp_ofs};
         end else if (addr_i == `A_EOT) begin
            rdata_o <= {20'h00000, eot_ofs};
         end else if (addr_i == `A_STATUS) begin
            rdata_o <= {6'h00, st_idx, 13'h0000, st_direct, st_accept, busy_o};
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------
   // Search engine
   // ----------------------------------------------------------
   wire at_end = (ptr >= hi) || ptr[9];

   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state     <= S_IDLE;
         sec       <= SEC_DS;
         ptr       <= 10'h000;
         phase     <= 1'b0;
         low_word  <= 32'h0000_0000;
         ctrl      <= 3'h0;
         ext       <= 1'b0;
         rtr       <= 1'b0;
         dlc       <= 4'h0;
         id        <= 29'h0000_0000;
         data_a    <= 32'h0000_0000;
         data_b    <= 32'h0000_0000;
         hit_idx   <= 10'h000;
         cnt       <= 2'h0;
         busy_o    <= 1'b0;
         done_o    <= 1'b0;
         accept_o  <= 1'b0;
         direct_o  <= 1'b0;
         index_o   <= 10'h000;
         st_accept <= 1'b0;
         st_direct <= 1'b0;
         st_idx    <= 10'h000;
      end else begin
         done_o <= 1'b0;
         case (state)
            S_IDLE: begin
               // RQ1 any controller may request
               if (req_i) begin
                  ctrl   <= req_ctrl_i;
                  ext    <= req_ext_i;
                  rtr    <= req_rtr_i;
                  dlc    <= req_dlc_i;
                  id     <= req_id_i;
                  data_a <= req_data_a_i;
                  data_b <= req_data_b_i;
                  phase  <= 1'b0;
                  busy_o <= 1'b1;
                  state  <= S_SCAN;
                  // RQ11 RQ16 standard requests search direct-store first when enabled
                  if (req_ext_i) begin
                     sec <= SEC_EE;
                     ptr <= word_of(ext_exp_ofs);
                  end else if (ds_en) begin
                     sec <= SEC_DS;
                     ptr <= 10'h000;
                  end else begin
                     sec <= SEC_SE;
                     ptr <= word_of(std_exp_ofs);
                  end
               end
            end
            S_SCAN: begin
               if (!sw_acc) begin
                  // RQ10 empty section skipped at once
                  if (at_end) begin
                     phase <= 1'b0;
                     // RQ5 fixed section order
                     if (sec == SEC_DS || sec == SEC_EE) begin
                        sec <= sec + 3'd1;
                        ptr <= hi;
                     end else if (sec == SEC_SE) begin
                        sec <= SEC_SG;
                        ptr <= hi;
                     end else begin
                        state     <= S_IDLE;
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        accept_o  <= 1'b0;
                        direct_o  <= 1'b0;
                        st_accept <= 1'b0;
                        st_direct <= 1'b0;
                     end
                  end else begin
                     ptr <= ptr + 10'h001;
                     case (sec)
                        SEC_DS: begin
                           // RQ3 RQ14 RQ15 index from word and half
                           if (hit_hi || hit_lo) begin
                              hit_idx <= {ptr[8:0], !hit_hi};
                              cnt     <= 2'h0;
                              state   <= S_STORE;
                           end
                        end
                        SEC_SE: begin
                           if (hit_hi || hit_lo) begin
                              state <= S_IDLE;
                           end
                        end
                        SEC_SG: begin
                           if (hit_sr) begin
                              state <= S_IDLE;
                           end
                        end
                        SEC_EE: begin
                           if (hit_ex) begin
                              state <= S_IDLE;
                           end
                        end
                        default: begin
                           phase    <= !phase;
                           low_word <= mem_q;
                           if (phase && hit_er) begin
                              state <= S_IDLE;
                           end
                        end
                     endcase
                     // RQ6 buffered sections accept via receive buffer
                     if ((sec == SEC_SE && (hit_hi || hit_lo)) || (sec == SEC_SG && hit_sr) ||
                         (sec == SEC_EE && hit_ex) || (sec == SEC_EG && phase && hit_er)) begin
                        busy_o    <= 1'b0;
                        done_o    <= 1'b1;
                        accept_o  <= 1'b1;
                        direct_o  <= 1'b0;
                        st_accept <= 1'b1;
                        st_direct <= 1'b0;
                     end
                  end
               end
            end
            S_STORE: begin
               // RQ6 RQ16 copy message into object area
               if (do_store) begin
                  cnt <= cnt + 2'h1;
                  if (cnt == `OBJ_WORDS - 1) begin
                     state     <= S_IDLE;
                     busy_o    <= 1'b0;
                     done_o    <= 1'b1;
                     accept_o  <= 1'b1;
                     direct_o  <= 1'b1;
                     index_o   <= hit_idx;
                     st_accept <= 1'b1;
                     st_direct <= 1'b1;
                     st_idx    <= hit_idx;
                  end
               end
            end
            default: begin
               state  <= S_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // can_id_acceptance_lookup

// file: rtl/entry_match.v
// Compares table words against a received identifier.
// Assumes request fields stay stable while a search runs.
`include "afilt_defines.vh"
module entry_match (
   // Table words
   input  wire [31:0] word_i,
   input  wire [31:0] low_word_i,
   // Received message
   input  wire [2:0]  ctrl_i,
   input  wire [28:0] id_i,
   // Results
   output wire        hit_hi_o,
   output wire        hit_lo_o,
   output wire        hit_std_range_o,
   output wire        hit_ext_o,
   output wire        hit_ext_range_o
);

   function half_hit;
      input [15:0] h;
      input [2:0]  c;
      input [10:0] id;
      begin
         // RQ19 disabled entry never hits
         half_hit = (h[`H_CTRL_HI:`H_CTRL_LO] == c) && !h[`H_DIS] &&
                    (h[`H_ID_HI:`H_ID_LO] == id);
      end
   endfunction

   wire [15:0] up = word_i[31:16];
   wire [15:0] dn = word_i[15:0];

   // RQ13 identifier and controller agree
   // RQ15 upper half even, lower odd
   assign hit_hi_o = half_hit(up, ctrl_i, id_i[10:0]);
   assign hit_lo_o = half_hit(dn, ctrl_i, id_i[10:0]);

   assign hit_std_range_o = (up[`H_CTRL_HI:`H_CTRL_LO] == ctrl_i) && !up[`H_DIS] &&
                            (id_i[10:0] >= up[`H_ID_HI:`H_ID_LO]) &&
                            (id_i[10:0] <= dn[`H_ID_HI:`H_ID_LO]);

   assign hit_ext_o = (word_i[`W_CTRL_HI:`W_CTRL_LO] == ctrl_i) &&
                      (word_i[`W_ID_HI:0] == id_i);

   assign hit_ext_range_o = (low_word_i[`W_CTRL_HI:`W_CTRL_LO] == ctrl_i) &&
                            (id_i >= low_word_i[`W_ID_HI:0]) &&
                            (id_i <= word_i[`W_ID_HI:0]);

endmodule // entry_match

// file: rtl/id_table_ram.v
// Identifier look-up table memory, one shared port.
// Assumes the caller arbitrates the single port each cycle.
module id_table_ram #(
   parameter DEPTH = 512,
   parameter AW    = 9
) (
   // Clock
   input  wire          mclk_i,
   // Port
   input  wire [AW-1:0] addr_i,
   input  wire          we_i,
   input  wire [31:0]   wdata_i,
   output wire [31:0]   rdata_o
);

   reg [31:0] mem [0:DEPTH-1];

   // ----------------------------------------------------------
   // Write and asynchronous read
   // ----------------------------------------------------------
   always @(posedge mclk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[addr_i];

endmodule // id_table_ram

// file: verif/lookup_chk.sv
// Checker for the identifier acceptance filter.
// Assumes it is bound to the filter top and sees its ports only.
module lookup_chk #(
   parameter DEPTH = 512
) (
   // Clock and reset
   input wire        mclk_i,
   input wire        rstn_i,
   // Register port
   input wire [11:0] addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   // Search
   input wire        req_i,
   input wire        req_ext_i,
   input wire        busy_o,
   input wire        done_o,
   input wire        accept_o,
   input wire        direct_o,
   input wire [9:0]  index_o
);
   timeunit 1ns;
   timeprecision 1ns;
   reg ds_en;
   reg ext_q;
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ds_en <= 1'b0;
         ext_q <= 1'b0;
      end else begin
         if (wr_i && addr_i == 12'h800)
            ds_en <= wdata_i[0];
         if (req_i && !busy_o)
            ext_q <= req_ext_i;
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside answer");
   AST_DONE_ONE: assert property (done_o |=> !done_o)
      else $error("done too long");
   AST_DONE_END: assert property (done_o |-> !busy_o && $past(busy_o))
      else $error("done without busy");
   AST_BOUND: assert property ($rose(busy_o) |-> ##[1:700] done_o)
      else $error("search too long");
   AST_HOLD: assert property (!done_o |-> $stable({accept_o, direct_o, index_o}))
      else $error("result moved");
   AST_DS_OFF: assert property (done_o && !ds_en |-> !direct_o)
      else $error("direct hit while off");
   AST_EXT_BUF: assert property (done_o && ext_q |-> !direct_o)
      else $error("extended direct hit");
   AST_STORE: assert property (done_o && direct_o |-> accept_o && $past(busy_o, 4))
      else $error("store too short");
   cover property (done_o && direct_o);
   cover property (done_o && accept_o && !direct_o);
   cover property (done_o && !accept_o);
endmodule // lookup_chk

bind can_id_acceptance_lookup lookup_chk #(.DEPTH(DEPTH)) chk_u (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .req_i(req_i), .req_ext_i(req_ext_i), .busy_o(busy_o),
   .done_o(done_o), .accept_o(accept_o), .direct_o(direct_o), .index_o(index_o));

// file: verif/rx_path_model.sv
// Receive path model presenting frames to the filter.
// Assumes busy is a registered level on the same clock.
module rx_path_model (
   // Clock and filter state
   input  wire        mclk_i,
   input  wire        busy_i,
   // Frame towards the filter
   output reg         req_o,
   output reg  [2:0]  ctrl_o,
   output reg         ext_o,
   output reg         rtr_o,
   output reg  [3:0]  dlc_o,
   output reg  [28:0] id_o,
   output reg  [31:0] da_o,
   output reg  [31:0] db_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      req_o = 1'b0;
      {ctrl_o, ext_o, rtr_o, dlc_o, id_o, da_o, db_o} = '0;
   end
   // ----
   // One frame, after a random gap
   // ----
   task send(input [2:0] c, input e, input [28:0] id, output [31:0] a, output [31:0] b,
             output r, output [3:0] l);
      int n;
      n = $urandom_range(3, 0);
      repeat (n) @(posedge mclk_i);
      a = $urandom;
      b = $urandom;
      r = 1'($urandom_range(1, 0));
      l = 4'($urandom_range(8, 0));
      n = 0;
      @(negedge mclk_i);
      while (busy_i !== 1'b0 && n < 800) begin
         @(negedge mclk_i);
         n++;
      end
      @(posedge mclk_i);
      req_o <= 1'b1;
      {ctrl_o, ext_o, rtr_o, dlc_o, id_o, da_o, db_o} <= {c, e, r, l, id, a, b};
      @(posedge mclk_i);
      req_o <= 1'b0;
      // Released fields lose their value
      {ctrl_o, ext_o, rtr_o, dlc_o, id_o, da_o, db_o} <= ~{c, e, r, l, id, a, b};
   endtask
endmodule // rx_path_model

// file: verif/test_can_id_acceptance_lookup.sv
// Self-checking bench for the identifier acceptance filter.
// Assumes the filter header constants and the receive path model.
`include "afilt_defines.vh"
module test_can_id_acceptance_lookup;
   timeunit 1ns;
   timeprecision 1ns;
   reg         mclk_i;
   reg         rstn_i;
   reg  [11:0] addr_i;
   reg  [31:0] wdata_i;
   reg         wr_i;
   reg         rd_i;
   wire [31:0] rdata_o;
   wire        req_i, req_ext_i, req_rtr_i;
   wire [2:0]  req_ctrl_i;
   wire [3:0]  req_dlc_i;
   wire [28:0] req_id_i;
   wire [31:0] req_data_a_i, req_data_b_i;
   wire        busy_o, done_o, accept_o, direct_o;
   wire [9:0]  index_o;
   int         n_fail;
   int         comparisons;
   int         i;
   int         k;
   reg  [31:0] w, wd, da, db;
   reg         rtr;
   reg  [3:0]  dlc;
   reg  [8:0]  ta;

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   can_id_acceptance_lookup dut_u (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .req_i(req_i), .req_ctrl_i(req_ctrl_i), .req_ext_i(req_ext_i),
      .req_rtr_i(req_rtr_i), .req_dlc_i(req_dlc_i), .req_id_i(req_id_i), .req_data_a_i(req_data_a_i),
      .req_data_b_i(req_data_b_i), .busy_o(busy_o), .done_o(done_o), .accept_o(accept_o),
      .direct_o(direct_o), .index_o(index_o));
   rx_path_model rx_u (
      .mclk_i(mclk_i), .busy_i(busy_o), .req_o(req_i), .ctrl_o(req_ctrl_i), .ext_o(req_ext_i),
      .rtr_o(req_rtr_i), .dlc_o(req_dlc_i), .id_o(req_id_i), .da_o(req_data_a_i), .db_o(req_data_b_i));

   // ----
   // Helpers
   // ----
   task chk(input [31:0] got, input [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task wr(input [11:0] a, input [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [11:0] a, output [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      d = rdata_o;
   endtask
   function [15:0] he(input [2:0] c, input d, input [10:0] id);
      he = {c, d, 1'b0, id};
   endfunction
   task wait_done;
      int n;
      n = 0;
      @(negedge mclk_i);
      while (done_o !== 1'b1) begin
         n++;
         if (n > 800) begin
            n_fail++;
            $display("mismatch at %0t: search hang", $time);
            results;
         end
         @(negedge mclk_i);
      end
   endtask
   task search(input [2:0] c, input e, input [28:0] id, input acc, input dir, input [9:0] x);
      rx_u.send(c, e, id, da, db, rtr, dlc);
      wait_done;
      chk(accept_o, acc);
      chk(direct_o, dir);
      if (dir) begin
         chk(index_o, x);
         for (k = 0; k < 3; k++) begin
            rd(12'(28 + 12 * x + 4 * k), w);
            chk(w, k == 0 ? {1'b0, rtr, 10'h0, dlc, 5'h0, id[10:0]} : k == 1 ? da : db);
         end
      end
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      void'($urandom(32'h6de64965));
      rstn_i = 1'b0;
      addr_i = 12'h0;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      n_fail = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(12'h800 + 12'(4 * i), w);
         chk(w, 32'h0);
      end
      wr(12'h81c, 32'hffffffff);
      rd(12'h81c, w);
      chk(w, 32'h0);
      wr(`A_EXT_EXP, 32'hfffff013);
      rd(`A_EXT_EXP, w);
      chk(w, 32'h10);
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         ta = i ? 9'($urandom_range(511, 32)) : 9'h1ff;
         wd = $urandom;
         wr({1'b0, ta, 2'b00}, wd);
         rd({1'b0, ta, 2'b00}, w);
         chk(w, wd);
      end
      $display("test table words done");
      wr(12'h000, {he(3'd1, 1'b0, 11'h010), he(3'd2, 1'b1, 11'h020)});
      wr(12'h004, {he(3'd5, 1'b0, 11'h030), he(3'd7, 1'b0, 11'h7ff)});
      wr(12'h008, {he(3'd1, 1'b0, 11'h123), he(3'd1, 1'b0, 11'h200)});
      wr(12'h00c, {he(3'd2, 1'b0, 11'h300), he(3'd2, 1'b0, 11'h37f)});
      wr(12'h010, {3'd3, 29'h1abcdef});
      wr(12'h014, {3'd3, 29'h100000});
      wr(12'h018, {3'd3, 29'h1fffff});
      wr(`A_STD_EXP, 32'h8);
      wr(`A_STD_GRP, 32'hc);
      wr(`A_EXT_EXP, 32'h10);
      wr(`A_EXT_GRP, 32'h14);
      wr(`A_EOT, 32'h1c);
      wr(`A_CTRL, 32'h1);
      search(3'd1, 1'b0, 29'h010, 1'b1, 1'b1, 10'd0);
      search(3'd2, 1'b0, 29'h020, 1'b0, 1'b0, 10'd0);
      search(3'd3, 1'b0, 29'h030, 1'b0, 1'b0, 10'd0);
      search(3'd7, 1'b0, 29'h7ff, 1'b1, 1'b1, 10'd3);
      rd(`A_STATUS, w);
      chk(w, 32'h00030006);
      search(3'd1, 1'b0, 29'h123, 1'b1, 1'b0, 10'd0);
      search(3'd1, 1'b0, 29'h200, 1'b1, 1'b0, 10'd0);
      search(3'd2, 1'b0, 29'h300, 1'b1, 1'b0, 10'd0);
      search(3'd2, 1'b0, 29'h380, 1'b0, 1'b0, 10'd0);
      search(3'd3, 1'b1, 29'h1abcdef, 1'b1, 1'b0, 10'd0);
      search(3'd3, 1'b1, 29'h150000, 1'b1, 1'b0, 10'd0);
      search(3'd4, 1'b1, 29'h150000, 1'b0, 1'b0, 10'd0);
      search(3'd1, 1'b1, 29'h010, 1'b0, 1'b0, 10'd0);
      for (i = 0; i < 4; i++)
         search(3'd0, 1'b0, 29'($urandom_range(2047, 1024)), 1'b0, 1'b0, 10'd0);
      $display("test search done");
      fork
         search(3'd5, 1'b0, 29'h030, 1'b1, 1'b1, 10'd2);
         begin
            for (i = 0; i < 20 && busy_o !== 1'b1; i++)
               @(negedge mclk_i);
            chk(busy_o, 1'b1);
            rd(12'h008, wd);
         end
      join
      chk(wd, {he(3'd1, 1'b0, 11'h123), he(3'd1, 1'b0, 11'h200)});
      $display("test arbitration done");
      wr(`A_CTRL, 32'h0);
      search(3'd1, 1'b0, 29'h010, 1'b0, 1'b0, 10'd0);
      search(3'd5, 1'b0, 29'h030, 1'b0, 1'b0, 10'd0);
      wr(`A_STD_EXP, 32'hc);
      search(3'd1, 1'b0, 29'h123, 1'b0, 1'b0, 10'd0);
      search(3'd2, 1'b0, 29'h300, 1'b1, 1'b0, 10'd0);
      $display("test disable and empty done");
      results;
   end
endmodule // test_can_id_acceptance_lookup
